// ==== hdl/psuoc_top.sv ====
// lamp, alert, power good and main on/off control of the supply
`timescale 1ns/10ps
module psuoc_top
  import psuoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire psuoc_cond_type cond,
  input wire logic removal_kill_input,
  input wire logic main_on_request_n,
  input wire logic restart_cmd,
  output psuoc_lamp_type lamp,
  output logic alert_line_n,
  output logic main_enable,
  output logic standby_enable,
  output logic power_good_out,
  output logic input_ok_out
);

  // ****************************************
  // input levels
  // ****************************************
  // open pins already arrive high through pull-ups
  wire removal_kill_level = removal_kill_input;
  wire main_on_request_level = ~main_on_request_n;

  // ****************************************
  // fault and warning decode
  // ****************************************
  // protection trips that stop the supply at once
  wire fault_ovp = cond.ovp;
  wire fault_ocp = cond.ocp;
  wire fault_otp = cond.otp;
  wire fault_fan = cond.fan_fail;
  wire fault_now = fault_ovp | fault_ocp | fault_otp | fault_fan;
  // conditions under which the supply keeps running
  wire warn_temp = cond.warn_temp;
  wire warn_power = cond.warn_power;
  wire warn_fan_slow = cond.warn_fan_slow;
  wire warning = warn_temp | warn_power | warn_fan_slow;

  // ****************************************
  // fan failure latch
  // ****************************************
  logic fan_latch;
  logic on_req_prev;
  logic mains_prev;
  // restart sources: request released, mains lost, bus restart
  wire on_req_toggle = on_req_prev & ~main_on_request_level;
  wire mains_cycle = mains_prev & ~cond.mains_present;
  wire latch_clear = on_req_toggle | mains_cycle | restart_cmd;
  // a new fan failure wins over a clear in the same cycle
  wire next_fan_latch = fault_fan | (fan_latch & ~latch_clear);

  // latch shutdown after fan failure
  always_ff @(posedge clk) begin
    if (rst) begin
      fan_latch <= RST_LATCH;
    end else begin
      fan_latch <= next_fan_latch;
    end
  end

  // previous request level for the toggle detect
  always_ff @(posedge clk) begin
    if (rst) begin
      on_req_prev <= 1'b0;
    end else begin
      on_req_prev <= main_on_request_level;
    end
  end

  // previous mains level for the recycle detect
  always_ff @(posedge clk) begin
    if (rst) begin
      mains_prev <= 1'b0;
    end else begin
      mains_prev <= cond.mains_present;
    end
  end

  // ****************************************
  // main on/off decision
  // ****************************************
  // any failure, live or latched, counts as critical
  wire critical = fault_now | fan_latch;
  // each on/off source as its own term
  wire kill_allows = ~removal_kill_level;
  wire request_on = main_on_request_level;
  wire mains_allows = cond.mains_present;
  wire faults_allow = ~critical;
  // kill high forces off whatever else asks
  wire next_main_enable = kill_allows & request_on & mains_allows & faults_allow;
  wire next_power_good = main_enable & cond.main_in_reg & ~critical;
  // alert on any critical or warning event
  wire next_alert_n = ~(critical | warning);
  // standby and input ok follow mains; kill leaves them alone
  wire next_standby_enable = cond.mains_present;
  wire next_input_ok = cond.mains_present;

  // ****************************************
  // lamp mode selection
  // ****************************************
  logic blink_phase;
  psuoc_mode_type mode;
  // one select line per display condition
  wire sel_dark = !cond.mains_present;
  wire sel_fail = critical;
  wire sel_warn = warning;
  wire sel_standby = !main_enable;
  // priority: no mains, failure, warning, standby, on
  assign mode = sel_dark ? PSUOC_DARK :
                sel_fail ? PSUOC_FAIL :
                sel_warn ? PSUOC_WARN :
                sel_standby ? PSUOC_STANDBY : PSUOC_ON_OK;

  // green blinks in standby only while the standby rail runs
  wire standby_green = blink_phase & cond.standby_on;

  // ****************************************
  // lamp patterns
  // ****************************************
  // fixed pattern of each mode, blink taken from the shared phase
  wire psuoc_lamp_type lamp_dark = '{green: 1'b0, amber: 1'b0};
  wire psuoc_lamp_type lamp_fail = '{green: 1'b0, amber: 1'b1};
  wire psuoc_lamp_type lamp_warn = '{green: 1'b0, amber: blink_phase};
  wire psuoc_lamp_type lamp_standby = '{green: standby_green, amber: 1'b0};
  wire psuoc_lamp_type lamp_on = '{green: 1'b1, amber: 1'b0};

  psuoc_lamp_type next_lamp;
  // pick the pattern of the current mode
  always_comb begin
    next_lamp = lamp_dark;
    case (mode)
      PSUOC_DARK: next_lamp = lamp_dark;
      PSUOC_FAIL: next_lamp = lamp_fail;
      PSUOC_WARN: next_lamp = lamp_warn;
      PSUOC_STANDBY: next_lamp = lamp_standby;
      PSUOC_ON_OK: next_lamp = lamp_on;
      default: next_lamp = lamp_dark;
    endcase
  end

  // shared blink phase for both lamps
  psuoc_blink psuoc_blink_i (
    .clk(clk),
    .rst(rst),
    .phase(blink_phase)
  );

  // ****************************************
  // output registers
  // ****************************************
  // lamp drive
  always_ff @(posedge clk) begin
    if (rst) begin
      lamp <= '{green: RST_LAMP, amber: RST_LAMP};
    end else begin
      lamp <= next_lamp;
    end
  end

  // alert line, low while anything needs a look
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_line_n <= RST_ALERT_N;
    end else begin
      alert_line_n <= next_alert_n;
    end
  end

  // main output enable
  always_ff @(posedge clk) begin
    if (rst) begin
      main_enable <= RST_MAIN_EN;
    end else begin
      main_enable <= next_main_enable;
    end
  end

  // standby stays up under kill
  always_ff @(posedge clk) begin
    if (rst) begin
      standby_enable <= RST_STANDBY_EN;
    end else begin
      standby_enable <= next_standby_enable;
    end
  end

  // power good flag
  always_ff @(posedge clk) begin
    if (rst) begin
      power_good_out <= RST_POWER_GOOD;
    end else begin
      power_good_out <= next_power_good;
    end
  end

  // input ok flag
  always_ff @(posedge clk) begin
    if (rst) begin
      input_ok_out <= RST_INPUT_OK;
    end else begin
      input_ok_out <= next_input_ok;
    end
  end

endmodule

// ==== hdl/psuoc_pkg.sv ====
// package of constants and carrier types for the status and on/off control block
package psuoc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 250000000;
  localparam int BLINK_HZ = 1;
  // half period of the blink pattern in clock cycles
  localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam int BLINK_CNT_W = 28;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_LAMP = 1'b0;
  localparam logic RST_ALERT_N = 1'b1;
  localparam logic RST_MAIN_EN = 1'b0;
  localparam logic RST_POWER_GOOD = 1'b0;
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_STANDBY_EN = 1'b0;
  localparam logic RST_INPUT_OK = 1'b0;

  // ****************************************
  // carrier types
  // ****************************************
  // conditions reported by the supply's analog and firmware side
  typedef struct packed {
    logic mains_present;  // input mains within limits
    logic standby_on;     // 3.3 v standby running
    logic main_in_reg;    // 12 v main between 10.9 v and 13.2 v
    logic ovp;            // overvoltage fault
    logic ocp;            // overcurrent fault
    logic otp;            // overtemperature fault
    logic fan_fail;       // fan failure
    logic warn_temp;      // high temperature warning
    logic warn_power;     // high power warning
    logic warn_fan_slow;  // slow fan warning
  } psuoc_cond_type;

  typedef struct packed {
    logic green;
    logic amber;
  } psuoc_lamp_type;

  // lamp display modes
  typedef enum logic [2:0] {
    PSUOC_DARK,
    PSUOC_FAIL,
    PSUOC_WARN,
    PSUOC_STANDBY,
    PSUOC_ON_OK
  } psuoc_mode_type;

endpackage

// ==== hdl/psuoc_blink.sv ====
// free-running divider that makes the shared 1 hz blink phase
`timescale 1ns/10ps
module psuoc_blink
  import psuoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic phase
);

  logic [BLINK_CNT_W-1:0] count;
  logic [BLINK_CNT_W-1:0] next_count;
  wire last = (count == BLINK_CNT_W'(BLINK_HALF_CYCLES - 1));

  // count half periods and wrap
  assign next_count = last ? '0 : count + BLINK_CNT_W'(1);

  // equal on and off halves from the clock
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      phase <= 1'b0;
    end else begin
      count <= next_count;
      if (last) begin
        phase <= ~phase;
      end
    end
  end

endmodule

// ==== testbench/psuoc_checker.sv ====
// port assertions for the status and on/off control block
`timescale 1ns/10ps
module psuoc_checker
  import psuoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire psuoc_cond_type cond,
  input wire logic removal_kill_input,
  input wire logic main_on_request_n,
  input wire logic restart_cmd,
  input wire psuoc_lamp_type lamp,
  input wire logic alert_line_n,
  input wire logic main_enable,
  input wire logic standby_enable,
  input wire logic power_good_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // fault, warning and latch-hold decodes
  wire logic flt = cond.ovp | cond.ocp | cond.otp | cond.fan_fail;
  wire logic wrn = cond.warn_temp | cond.warn_power | cond.warn_fan_slow;
  wire logic hold = !cond.fan_fail && !restart_cmd && !main_on_request_n && cond.mains_present;
  AST_DARK: assert property (!cond.mains_present |=> lamp == 2'b00) else $error("lamp lit");
  AST_FAIL: assert property (flt && cond.mains_present |=> lamp == 2'b01) else $error("fail lamp");
  AST_WARN: assert property (wrn |=> !lamp.green) else $error("green in warning");
  AST_LATCH: assert property (cond.fan_fail ##1 hold [*3] |=> !main_enable) else $error("fan latch");
  AST_ALERT: assert property (cond.mains_present && (flt || wrn) |=> !alert_line_n) else $error("alert");
  AST_KILL: assert property (removal_kill_input && cond.mains_present |=> !main_enable && standby_enable)
    else $error("kill");
  AST_ONLY: assert property (main_enable |-> !$past(removal_kill_input) && !$past(main_on_request_n))
    else $error("main on");
  AST_PG: assert property (flt || !cond.main_in_reg |=> !power_good_out) else $error("power good");
endmodule

// ==== testbench/psuoc_host.sv ====
// host model: chassis kill wiring and open-drain on request
`timescale 1ns/10ps
module psuoc_host (
  input wire logic inserted,
  input wire logic want_on,
  output logic removal_kill_input,
  output logic main_on_request_n
);
  // presence is a plain ground tie the host counts; no logic here
  // tied to return when seated, pulled up when open
  assign removal_kill_input = inserted ? 1'b0 : 1'b1;
  assign main_on_request_n = want_on ? 1'b0 : 1'b1;
endmodule

// ==== testbench/psu_status_onoff_control_tb.sv ====
// self-checking bench for the status and on/off control block
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("BAD %0t %h %h", $time, a, b); end end
module psu_status_onoff_control_tb;
  import psuoc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, inserted = 1'b0, want_on = 1'b0, restart_cmd = 1'b0;
  logic removal_kill_input, main_on_request_n, alert_line_n, main_enable, standby_enable, power_good_out, input_ok_out;
  psuoc_cond_type cond = '0;
  psuoc_lamp_type lamp;
  int errors = 0, comparisons = 0;
  // 4 ns clock, host model and block
  initial forever #2 clk = ~clk;
  psuoc_host psuoc_host_i (.*);
  psuoc_top psuoc_top_i (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_off;
    cyc(2);
    `CHK({lamp, main_enable, input_ok_out}, 4'h0)
  endtask
  task automatic t_on;
    @(posedge clk);
    cond <= 10'h380;
    inserted <= 1'b1;
    want_on <= 1'b1;
    cyc(4);
    `CHK({lamp, main_enable, power_good_out, alert_line_n, input_ok_out}, 6'h2f)
  endtask
  // pulled kill: main off, standby kept
  task automatic t_kill;
    @(posedge clk);
    inserted <= 1'b0;
    cyc(3);
    `CHK({lamp, main_enable, standby_enable}, 4'h1)
    @(posedge clk);
    inserted <= 1'b1;
    cyc(4);
  endtask
  // each fault but fan failure, and each warning, in turn
  task automatic t_events;
    for (int i = 0; i < 7; i++) begin
      if (i == 3) continue;
      @(posedge clk);
      cond[i] <= 1'b1;
      cyc(3);
      `CHK({lamp, alert_line_n, main_enable, power_good_out}, (i > 3) ? 5'h08 : 5'h03)
      @(posedge clk);
      cond[i] <= 1'b0;
      cyc(4);
    end
  endtask
  // fan latch, cleared by request toggle, then by restart, then by mains recycle
  task automatic t_fan;
    @(posedge clk);
    cond.fan_fail <= 1'b1;
    @(posedge clk);
    cond.fan_fail <= 1'b0;
    cyc(4);
    `CHK({lamp, main_enable}, 3'h2)
    @(posedge clk);
    want_on <= 1'b0;
    @(posedge clk);
    want_on <= 1'b1;
    cyc(4);
    `CHK({lamp, main_enable}, 3'h5)
    @(posedge clk);
    cond.fan_fail <= 1'b1;
    @(posedge clk);
    cond.fan_fail <= 1'b0;
    restart_cmd <= 1'b1;
    @(posedge clk);
    restart_cmd <= 1'b0;
    cyc(4);
    `CHK({lamp, main_enable}, 3'h5)
    @(posedge clk);
    cond.fan_fail <= 1'b1;
    @(posedge clk);
    cond.fan_fail <= 1'b0;
    cond.mains_present <= 1'b0;
    @(posedge clk);
    cond.mains_present <= 1'b1;
    cyc(4);
    `CHK({lamp, main_enable}, 3'h5)
  endtask
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_off();
    t_on();
    t_kill();
    t_events();
    t_fan();
    final_report();
  end
  // watchdog
  initial begin
    #4000;
    errors++;
    final_report();
  end
endmodule
bind psuoc_top psuoc_checker psuoc_checker_i (.*);
